// ===== logic/pfdc_pkg.sv
// Package: constants and types of the program fetch and decode core
package pfdc_pkg;
  localparam logic [7:0] PFDC_OFS_IMR = 8'hfb;
  localparam logic [7:0] PFDC_OFS_FLAGS = 8'hfc;
  localparam logic [7:0] PFDC_OFS_RP = 8'hfd;
  localparam logic [7:0] PFDC_OFS_SPH = 8'hfe;
  localparam logic [7:0] PFDC_OFS_SPL = 8'hff;
  localparam logic [7:0] PFDC_OFS_CTRL = 8'hf0;
  localparam logic [7:0] PFDC_OFS_STAT = 8'hf1;
  localparam logic [7:0] PFDC_OFS_PCH = 8'hf2;
  localparam logic [7:0] PFDC_OFS_PCL = 8'hf3;
  localparam logic [7:0] PFDC_OFS_OPC = 8'hf4;
  localparam logic [7:0] PFDC_OFS_OPND = 8'hf5;
  localparam logic [7:0] PFDC_OFS_DST = 8'hf6;
  localparam logic [7:0] PFDC_OFS_SRC = 8'hf7;
  localparam int PFDC_IMR_GIE_BIT = 7;
  localparam int PFDC_FLG_C = 7;
  localparam int PFDC_FLG_Z = 6;
  localparam int PFDC_FLG_S = 5;
  localparam int PFDC_FLG_V = 4;
  localparam int PFDC_CTRL_RUN = 0;
  localparam int PFDC_CTRL_IRQ = 1;
  localparam logic [7:0] PFDC_RST_BYTE = 8'h00;
  localparam logic [11:0] PFDC_RST_PC = 12'h00c;
  localparam logic [15:0] PFDC_ROM_TOP = 16'h0800;
  localparam logic [3:0] PFDC_HI_AND = 4'h5;
  localparam logic [7:0] PFDC_OP_JP_IRR = 8'h30;
  localparam logic [7:0] PFDC_OP_DI = 8'h8f;
  localparam logic [7:0] PFDC_OP_EI = 8'h9f;
  localparam logic [3:0] PFDC_LO_JR = 4'hb;
  localparam logic [3:0] PFDC_LO_JP = 4'hd;
  localparam logic [3:0] PFDC_WREG_PAGE = 4'he;
  localparam logic [1:0] PFDC_CLK_DIV = 2'h2;
  typedef enum logic [2:0] {
    PFDC_IDLE = 3'b000,
    PFDC_SYNC = 3'b001,
    PFDC_OPC = 3'b010,
    PFDC_OP1 = 3'b011,
    PFDC_OP2 = 3'b100,
    PFDC_EXEC = 3'b101,
    PFDC_INTERRUPT_ACKNOWLEDGE = 3'b110,
    PFDC_RSVD = 3'b111
  } pfdc_state_t;
endpackage

// ===== logic/pfdc_fetch_if.sv
// Interface: fetch request and returned byte between core and fetch port
`timescale 1ns/1ps
`default_nettype none
interface pfdc_fetch_if;
  logic req;
  logic sync;
  logic [11:0] addr;
  logic done;
  logic [7:0] data;
  modport core(output req, output sync, output addr, input done, input data);
  modport port(input req, input sync, input addr, output done, output data);
endinterface
`default_nettype wire

// ===== logic/pfdc_fetch_port.sv
// Fetch port: clock halving, strobes and byte capture on the program memory pins
`timescale 1ns/1ps
`default_nettype none
module pfdc_fetch_port
  import pfdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  pfdc_fetch_if.port f,
  input wire logic [7:0] program_data_bus_i,
  output logic [11:0] program_address_bus_o,
  output logic program_fetch_strobe_n_o,
  output logic opcode_sync_n_o,
  output logic system_clock_o
);
  typedef struct packed {
    logic sclk;
    logic busy;
    logic done;
    logic [7:0] data;
    logic [11:0] addr;
    logic strobe_n;
    logic sync_n;
    logic pre;
  } pfdc_port_t;
  pfdc_port_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk = ~s_r.sclk; // RQ5
    s_nxt.done = 1'b0;
    if (s_r.sclk) begin
      // Strobes change only as the system clock output falls
      s_nxt.sync_n = 1'b1; // RQ4 RQ18
      s_nxt.pre = 1'b0;
      if (s_r.busy) begin
        s_nxt.data = program_data_bus_i; // RQ7
        s_nxt.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.strobe_n = 1'b1;
      end else if (f.req && f.sync && !s_r.pre && !s_r.done) begin
        // Opcode fetch: one sync period first, strobe on the next
        s_nxt.sync_n = 1'b0; // RQ4 RQ18
        s_nxt.pre = 1'b1;
      end else if (f.req && !f.done && !s_r.done) begin
        s_nxt.busy = 1'b1;
        s_nxt.addr = f.addr; // RQ1
        s_nxt.addr[11] = 1'b0; // RQ1
        s_nxt.strobe_n = ({4'h0, f.addr} >= PFDC_ROM_TOP); // RQ3 RQ18
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '{sclk: 1'b0, busy: 1'b0, done: 1'b0, data: PFDC_RST_BYTE, addr: 12'h000,
               strobe_n: 1'b1, sync_n: 1'b1, pre: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign f.done = s_r.done;
  assign f.data = s_r.data;
  assign program_address_bus_o = s_r.addr;
  assign program_fetch_strobe_n_o = s_r.strobe_n;
  assign opcode_sync_n_o = s_r.sync_n;
  assign system_clock_o = s_r.sclk;
  strobe_edge_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(s_r.strobe_n) |-> !s_r.sclk) else $error("strobe not on clock edge"); // RQ18
  sync_width_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(s_r.sync_n) |=> !s_r.sync_n ##1 s_r.sync_n) else $error("sync not one period"); // RQ4
  sclk_toggle_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(reset_i) |-> s_r.sclk != $past(s_r.sclk)) else $error("system clock not halved"); // RQ5
  addr_top_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !s_r.addr[11]) else $error("reserved address line driven"); // RQ1
endmodule
`default_nettype wire

// ===== logic/pfdc_core.sv
// Core: instruction fetch sequencing, decode and Avalon-MM control registers
// Function
// [RQ1] Drive twelve program address lines for the lowest 2K, top line reserved.
// [RQ2] External memory returns instruction bytes on the eight data inputs.
// [RQ3] Fetch strobe low during fetches inside the lowest 2K, high otherwise.
// [RQ4] Opcode sync low for one system clock period before each opcode fetch.
// [RQ5] System clock output runs at half the input clock rate.
// [RQ6] Interrupt acknowledge high during the interrupt machine cycle.
// [RQ7] Bytes consumed as opcode, first operand, second operand.
// [RQ8] Unassigned opcodes decode as reserved, no defined operation.
// [RQ9] Two-operand ALU: high nibble operation, low nibble addressing mode pair.
// [RQ10] High nibble 5 is AND into destination, overflow cleared, zero and sign set.
// [RQ11] Interrupt mask bit 7 is global enable; disable clears, enable sets.
// [RQ12] Sixteen-bit stack pointer lives at control registers 254 and 255.
// [RQ13] Flags at register 252, working group pointer at register 253.
// [RQ14] Relative branch adds signed displacement only when condition is true.
// [RQ15] Absolute jump loads direct or indirect target when true; indirect is 30.
// [RQ16] Full operands are 8-bit addresses, working operands 4-bit in group.
// [RQ17] Program counter advances by one after each fetched byte.
// [RQ18] Strobe and sync changes align to system clock output edges.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module pfdc_core
  import pfdc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [7:0] program_data_bus_i,
  output logic [11:0] program_address_bus_o,
  output logic program_fetch_strobe_n_o,
  output logic opcode_sync_n_o,
  output logic system_clock_o,
  output logic interrupt_acknowledge_o
);
  if (ADDR_W != 12) begin : g_addr_w_check
    $error("program address width must be 12");
  end
  ////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] fl);
    logic c, z, s, v;
    c = fl[PFDC_FLG_C];
    z = fl[PFDC_FLG_Z];
    s = fl[PFDC_FLG_S];
    v = fl[PFDC_FLG_V];
    case (cc)
      4'h0: cond_true = 1'b0;
      4'h1: cond_true = s ^ v;
      4'h2: cond_true = z | (s ^ v);
      4'h3: cond_true = c | z;
      4'h4: cond_true = v;
      4'h5: cond_true = s;
      4'h6: cond_true = z;
      4'h7: cond_true = c;
      4'h8: cond_true = 1'b1;
      4'h9: cond_true = ~(s ^ v);
      4'ha: cond_true = ~(z | (s ^ v));
      4'hb: cond_true = ~(c | z);
      4'hc: cond_true = ~v;
      4'hd: cond_true = ~s;
      4'he: cond_true = ~z;
      default: cond_true = ~c;
    endcase
  endfunction
  // Working operand becomes full address inside selected group
  function automatic logic [7:0] reg_addr(input logic [7:0] raw, input logic [7:0] rp);
    if (raw[7:4] == PFDC_WREG_PAGE) begin
      reg_addr = {rp[7:4], raw[3:0]}; // RQ16
    end else begin
      reg_addr = raw; // RQ16
    end
  endfunction
  function automatic logic [1:0] op_len(input logic [7:0] op);
    if (op == PFDC_OP_DI || op == PFDC_OP_EI) begin
      op_len = 2'd0;
    end else if (op[3:0] == PFDC_LO_JR || op == PFDC_OP_JP_IRR) begin
      op_len = 2'd1;
    end else if (op[3:0] == PFDC_LO_JP) begin
      op_len = 2'd2;
    end else if (op[3:0] >= 4'h2 && op[3:0] <= 4'h7 && op[7:4] <= 4'ha) begin
      op_len = (op[3:0] >= 4'h4) ? 2'd2 : 2'd1; // RQ9
    end else begin
      op_len = 2'd3;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    pfdc_state_t st;
    logic [11:0] pc;
    logic [7:0] opc;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [7:0] interrupt_mask;
    logic [7:0] flags;
    logic [7:0] rp;
    logic [15:0] sp;
    logic [7:0] dst;
    logic [7:0] src;
    logic run;
    logic irq;
    logic rsvd;
    logic interrupt_acknowledge;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [31:0] rdata;
    logic ack;
  } pfdc_core_t;
  pfdc_core_t s_r, s_nxt;
  pfdc_fetch_if fif();
  logic [1:0] need;
  logic [7:0] res;
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    need = op_len(s_r.opc);
    res = s_r.alu_a & s_r.alu_b;
    case (s_r.st)
      PFDC_IDLE: begin
        if (s_r.run) begin
          s_nxt.st = PFDC_SYNC;
        end
      end
      PFDC_SYNC: begin
        // A byte already fetched is taken before any grant
        if (fif.done) begin
          s_nxt.opc = fif.data; // RQ7
          s_nxt.pc = s_r.pc + 12'h001; // RQ17
          s_nxt.st = PFDC_OPC;
        end else if (s_r.irq && s_r.interrupt_mask[PFDC_IMR_GIE_BIT]) begin
          s_nxt.st = PFDC_INTERRUPT_ACKNOWLEDGE;
          s_nxt.interrupt_acknowledge = 1'b1; // RQ6
          s_nxt.interrupt_mask[PFDC_IMR_GIE_BIT] = 1'b0;
          s_nxt.irq = 1'b0;
          s_nxt.sp = s_r.sp - 16'h0003; // RQ12
        end
      end
      PFDC_OPC: begin
        if (need == 2'd3) begin
          s_nxt.rsvd = 1'b1; // RQ8
          s_nxt.st = PFDC_RSVD;
        end else if (need == 2'd0) begin
          s_nxt.st = PFDC_EXEC;
        end else begin
          s_nxt.st = PFDC_OP1;
        end
      end
      PFDC_OP1: begin
        if (fif.done) begin
          s_nxt.op1 = fif.data; // RQ7
          s_nxt.pc = s_r.pc + 12'h001; // RQ17
          s_nxt.st = (need == 2'd2) ? PFDC_OP2 : PFDC_EXEC;
        end
      end
      PFDC_OP2: begin
        if (fif.done) begin
          s_nxt.op2 = fif.data; // RQ7
          s_nxt.pc = s_r.pc + 12'h001; // RQ17
          s_nxt.st = PFDC_EXEC;
        end
      end
      PFDC_EXEC: begin
        s_nxt.st = PFDC_SYNC;
        if (s_r.opc == PFDC_OP_DI) begin
          s_nxt.interrupt_mask[PFDC_IMR_GIE_BIT] = 1'b0; // RQ11
        end else if (s_r.opc == PFDC_OP_EI) begin
          s_nxt.interrupt_mask[PFDC_IMR_GIE_BIT] = 1'b1; // RQ11
        end else if (s_r.opc[3:0] == PFDC_LO_JR) begin
          if (cond_true(s_r.opc[7:4], s_r.flags)) begin
            s_nxt.pc = s_r.pc + {{4{s_r.op1[7]}}, s_r.op1}; // RQ14
          end
        end else if (s_r.opc == PFDC_OP_JP_IRR) begin
          s_nxt.dst = reg_addr(s_r.op1, s_r.rp); // RQ15
          s_nxt.pc = {s_r.alu_a[3:0], s_r.alu_b}; // RQ15
        end else if (s_r.opc[3:0] == PFDC_LO_JP) begin
          if (cond_true(s_r.opc[7:4], s_r.flags)) begin
            s_nxt.pc = {s_r.op1[3:0], s_r.op2}; // RQ15
          end
        end else begin
          // Mode pair: 2..3 hold nibble operands, 4..7 full byte operands
          if (s_r.opc[3:0] <= 4'h3) begin
            s_nxt.dst = reg_addr({PFDC_WREG_PAGE, s_r.op1[7:4]}, s_r.rp); // RQ9 RQ16
            s_nxt.src = reg_addr({PFDC_WREG_PAGE, s_r.op1[3:0]}, s_r.rp); // RQ9 RQ16
          end else begin
            s_nxt.dst = reg_addr(s_r.op2, s_r.rp); // RQ9 RQ16
            s_nxt.src = reg_addr(s_r.op1, s_r.rp); // RQ9 RQ16
          end
          if (s_r.opc[7:4] == PFDC_HI_AND) begin
            s_nxt.alu_a = res; // RQ10
            s_nxt.flags[PFDC_FLG_V] = 1'b0; // RQ10
            s_nxt.flags[PFDC_FLG_Z] = (res == 8'h00); // RQ10
            s_nxt.flags[PFDC_FLG_S] = res[7]; // RQ10
          end
        end
      end
      PFDC_INTERRUPT_ACKNOWLEDGE: begin
        s_nxt.interrupt_acknowledge = 1'b0;
        s_nxt.st = PFDC_SYNC;
      end
      default: begin
        s_nxt.st = s_r.run ? PFDC_RSVD : PFDC_IDLE;
      end
    endcase
    if (!s_r.run && s_r.st != PFDC_INTERRUPT_ACKNOWLEDGE) begin
      s_nxt.st = PFDC_IDLE;
    end
    ////////////////////////////////////////////////////////////////////
    // Avalon-MM slave, one-cycle wait then answer
    if ((avs_read_i || avs_write_i) && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = 32'h0000_0000;
      case (avs_address_i)
        PFDC_OFS_IMR: s_nxt.rdata[7:0] = s_r.interrupt_mask;
        PFDC_OFS_FLAGS: s_nxt.rdata[7:0] = s_r.flags;
        PFDC_OFS_RP: s_nxt.rdata[7:0] = s_r.rp;
        PFDC_OFS_SPH: s_nxt.rdata[7:0] = s_r.sp[15:8];
        PFDC_OFS_SPL: s_nxt.rdata[7:0] = s_r.sp[7:0];
        PFDC_OFS_CTRL: s_nxt.rdata[7:0] = {6'h00, s_r.irq, s_r.run};
        PFDC_OFS_STAT: s_nxt.rdata[7:0] = {4'h0, s_r.rsvd, s_r.st};
        PFDC_OFS_PCH: s_nxt.rdata[7:0] = {4'h0, s_r.pc[11:8]};
        PFDC_OFS_PCL: s_nxt.rdata[7:0] = s_r.pc[7:0];
        PFDC_OFS_OPC: s_nxt.rdata[7:0] = s_r.opc;
        PFDC_OFS_OPND: s_nxt.rdata[15:0] = {s_r.op2, s_r.op1};
        PFDC_OFS_DST: s_nxt.rdata[7:0] = s_r.dst;
        PFDC_OFS_SRC: s_nxt.rdata[7:0] = s_r.src;
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Write lands at the edge where waitrequest is seen low
    if (avs_write_i && s_r.ack && avs_byteenable_i[0]) begin
        case (avs_address_i)
          PFDC_OFS_IMR: s_nxt.interrupt_mask = avs_writedata_i[7:0];
          PFDC_OFS_FLAGS: s_nxt.flags = avs_writedata_i[7:0]; // RQ13
          PFDC_OFS_RP: s_nxt.rp = avs_writedata_i[7:0]; // RQ13
          PFDC_OFS_SPH: s_nxt.sp[15:8] = avs_writedata_i[7:0]; // RQ12
          PFDC_OFS_SPL: s_nxt.sp[7:0] = avs_writedata_i[7:0]; // RQ12
          PFDC_OFS_CTRL: begin
            s_nxt.run = avs_writedata_i[PFDC_CTRL_RUN];
            // Writing zero keeps a pending request only while in the sync state
            s_nxt.irq = avs_writedata_i[PFDC_CTRL_IRQ] | s_nxt.irq;
            if (!avs_writedata_i[PFDC_CTRL_IRQ] && s_r.st != PFDC_SYNC) begin
              s_nxt.irq = 1'b0;
            end
            // Reserved flag set in this same cycle wins over the clear
            s_nxt.rsvd = s_nxt.rsvd && !s_r.rsvd;
          end
          // Operand values feed the AND datapath and indirect target
          PFDC_OFS_DST: s_nxt.alu_a = avs_writedata_i[7:0];
          PFDC_OFS_SRC: s_nxt.alu_b = avs_writedata_i[7:0];
          default: s_nxt.run = s_nxt.run;
        endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '{st: PFDC_IDLE, pc: PFDC_RST_PC, opc: 8'h00, op1: 8'h00, op2: 8'h00,
               interrupt_mask: PFDC_RST_BYTE, flags: PFDC_RST_BYTE, rp: PFDC_RST_BYTE, sp: 16'h0000,
               dst: 8'h00, src: 8'h00, run: 1'b0, irq: 1'b0, rsvd: 1'b0, interrupt_acknowledge: 1'b0,
               alu_a: 8'h00, alu_b: 8'h00, rdata: 32'h0000_0000, ack: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Fetch port
  assign fif.req = (s_r.st == PFDC_SYNC || s_r.st == PFDC_OP1 || s_r.st == PFDC_OP2) &&
                   !(s_r.st == PFDC_SYNC && s_r.irq && s_r.interrupt_mask[PFDC_IMR_GIE_BIT]);
  assign fif.sync = (s_r.st == PFDC_SYNC);
  assign fif.addr = s_r.pc;
  pfdc_fetch_port u_port (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .f(fif),
    .program_data_bus_i(program_data_bus_i), // RQ2
    .program_address_bus_o(program_address_bus_o),
    .program_fetch_strobe_n_o(program_fetch_strobe_n_o),
    .opcode_sync_n_o(opcode_sync_n_o),
    .system_clock_o(system_clock_o)
  );
  assign avs_readdata_o = s_r.rdata;
  assign avs_waitrequest_o = !s_r.ack;
  assign interrupt_acknowledge_o = s_r.interrupt_acknowledge;
  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence fetch_done_s;
    fif.done && (s_r.st == PFDC_SYNC || s_r.st == PFDC_OP1 || s_r.st == PFDC_OP2);
  endsequence
  pc_advance_a: assert property (@(posedge clk_i) disable iff (reset_i)
    fetch_done_s and s_r.run |=> s_r.pc == $past(s_r.pc) + 12'h001) else $error("pc not advanced"); // RQ17
  di_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == PFDC_EXEC && s_r.opc == PFDC_OP_DI && !avs_write_i |=> !s_r.interrupt_mask[7]) else $error("disable failed"); // RQ11
  ei_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == PFDC_EXEC && s_r.opc == PFDC_OP_EI && !avs_write_i |=> s_r.interrupt_mask[7]) else $error("enable failed"); // RQ11
  and_flags_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == PFDC_EXEC && s_r.opc[7:4] == PFDC_HI_AND && s_r.opc[3:0] >= 4'h2 && s_r.opc[3:0] <= 4'h7
    && !avs_write_i |=> !s_r.flags[PFDC_FLG_V] && s_r.flags[PFDC_FLG_Z] == (s_r.alu_a == 8'h00))
    else $error("and flags wrong"); // RQ10
  jr_false_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == PFDC_EXEC && s_r.opc[3:0] == PFDC_LO_JR && s_r.opc[7:4] == 4'h0 |=> $stable(s_r.pc))
    else $error("never branch taken"); // RQ14
  rsvd_stop_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == PFDC_OPC && op_len(s_r.opc) == 2'd3 |=> s_r.st == PFDC_RSVD && s_r.rsvd)
    else $error("reserved opcode decoded"); // RQ8
  interrupt_acknowledge_cycle_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(s_r.interrupt_acknowledge) |-> s_r.st == PFDC_INTERRUPT_ACKNOWLEDGE ##1 !s_r.interrupt_acknowledge) else $error("acknowledge misplaced"); // RQ6
  bus_wait_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("bus stalled"); // RQ13
endmodule
`default_nettype wire

// ===== tb/pfdc_prog_mem.sv
// Program memory model for the lowest 2K of program space
`timescale 1ns/1ps
`default_nettype none
module pfdc_prog_mem (
  input wire logic clk_i,
  input wire logic [11:0] program_address_bus_i,
  input wire logic program_fetch_strobe_n_i,
  output logic [7:0] program_data_bus_o
);
  logic [7:0] mem [0:2047];
  logic [7:0] last_r = 8'h00;
  // Released bus shows the inverted last byte, never a held value
  always_comb begin
    if (program_fetch_strobe_n_i === 1'b0) begin
      program_data_bus_o = mem[program_address_bus_i[10:0]];
    end else begin
      program_data_bus_o = ~last_r;
    end
  end
  always @(posedge clk_i) begin
    if (program_fetch_strobe_n_i === 1'b0) begin
      last_r <= mem[program_address_bus_i[10:0]];
    end
  end
endmodule
`default_nettype wire

// ===== tb/pfdc_core_tb.sv
// Self-checking bench of the fetch and decode core
`timescale 1ns/1ps
`default_nettype none
module pfdc_core_tb;
  import pfdc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [7:0] prog_data;
  logic [11:0] prog_addr;
  logic strobe_n, sync_n, sclk, interrupt_acknowledge;
  logic strobe_d = 1'b1;
  logic sync_d = 1'b1;
  logic sclk_d = 1'b0;
  logic chk_fetch = 1'b1;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int since_rst = 0;
  int sync_len = 0;
  int strb_len = 0;
  int interrupt_acknowledge_len = 0;
  int interrupt_acknowledge_cnt = 0;
  logic [31:0] rq[$];
  logic [31:0] fq[$];
  logic [7:0] regs[5] = '{PFDC_OFS_IMR, PFDC_OFS_FLAGS, PFDC_OFS_RP, PFDC_OFS_SPH, PFDC_OFS_SPL};
  logic [7:0] v;
  logic [7:0] halted;

  pfdc_core pfdc_core_i (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .program_data_bus_i(prog_data),
    .program_address_bus_o(prog_addr), .program_fetch_strobe_n_o(strobe_n),
    .opcode_sync_n_o(sync_n), .system_clock_o(sclk), .interrupt_acknowledge_o(interrupt_acknowledge));
  pfdc_prog_mem pfdc_prog_mem_i (.clk_i(clk_i), .program_address_bus_i(prog_addr),
    .program_fetch_strobe_n_i(strobe_n), .program_data_bus_o(prog_data));

  always #2.5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic pulse(input logic lvl, inout int len, input int exp, input string what);
    if (lvl) begin
      len++;
    end else begin
      if (len != 0) chk(len, exp, what);
      len = 0;
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic acc(input logic [7:0] a, input logic wr, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= {24'($urandom()), d};
    avs_byteenable_i <= be;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, 1'b1, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rq.push_back({24'h0, exp});
    acc(a, 1'b0, 8'h00, 4'hf);
  endtask

  task automatic rst;
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    fq.delete();
    for (int i = 0; i < 2048; i++) pfdc_prog_mem_i.mem[i] = 8'h0f;
  endtask

  // Places a byte and notes the fetch expected for it
  task automatic pf(input logic op, input logic [11:0] a, input logic [7:0] b);
    pfdc_prog_mem_i.mem[a[10:0]] = b;
    fq.push_back({19'h0, op, a});
  endtask

  task automatic run_done;
    wr(PFDC_OFS_CTRL, 8'h01);
    for (int i = 0; i < 2000 && fq.size() > 0; i++) @(posedge clk_i);
    if (fq.size() != 0) chk(fq.size(), 0, "fetches missing");
    repeat (20) @(posedge clk_i);
    rd(PFDC_OFS_STAT, halted);
    rd(PFDC_OFS_OPC, 8'h0f);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      stop_test();
    end
    if (avs_read_i && avs_waitrequest_o === 1'b0) chk(avs_readdata_o, rq.pop_front(), "register read");
    since_rst = reset_i ? 0 : since_rst + 1;
    if (since_rst > 2) chk({31'h0, sclk}, {31'h0, ~sclk_d}, "system clock toggle");
    if (strobe_d === 1'b1 && strobe_n === 1'b0 && chk_fetch) begin
      chk({19'h0, sync_d === 1'b0, prog_addr}, fq.pop_front(), "fetch address and sync");
    end
    pulse(sync_n === 1'b0, sync_len, 2, "sync width");
    pulse(strobe_n === 1'b0, strb_len, 2, "strobe width");
    if (interrupt_acknowledge === 1'b1 && interrupt_acknowledge_len == 0) interrupt_acknowledge_cnt++;
    pulse(interrupt_acknowledge === 1'b1, interrupt_acknowledge_len, 1, "acknowledge width");
    strobe_d = strobe_n;
    sync_d = sync_n;
    sclk_d = sclk;
  end

  initial begin
    halted = {4'h0, 1'b1, PFDC_RSVD};
    void'($urandom(32'hb41b));
    for (int i = 0; i < 2048; i++) pfdc_prog_mem_i.mem[i] = 8'h0f;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(PFDC_OFS_PCH, 8'h00);
    rd(PFDC_OFS_PCL, 8'h0c);
    for (int i = 0; i < 5; i++) begin
      v = $urandom();
      wr(regs[i], v);
      rd(regs[i], v);
    end
    acc(PFDC_OFS_SPL, 1'b1, ~v, 4'h0);
    rd(PFDC_OFS_SPL, v);
    wr(8'h10, v);
    rd(8'h10, 8'h00);
    $display("test registers done");
    // Enable, then forward branch of +127
    rst();
    wr(PFDC_OFS_IMR, 8'h05);
    pf(1'b1, 12'h00c, PFDC_OP_EI);
    pf(1'b1, 12'h00d, {4'h8, PFDC_LO_JR});
    pf(1'b0, 12'h00e, 8'h7f);
    pf(1'b1, 12'h08e, 8'h0f);
    run_done();
    rd(PFDC_OFS_IMR, 8'h85);
    $display("test enable and forward branch done");
    // Untaken branch, direct jump, branch of -128, indirect jump, disable, AND
    rst();
    wr(PFDC_OFS_IMR, 8'hff);
    wr(PFDC_OFS_DST, 8'h01);
    wr(PFDC_OFS_SRC, 8'h23);
    wr(PFDC_OFS_FLAGS, 8'hd0);
    pf(1'b1, 12'h00c, {4'h0, PFDC_LO_JR});
    pf(1'b0, 12'h00d, 8'h40);
    pf(1'b1, 12'h00e, {4'h8, PFDC_LO_JP});
    pf(1'b0, 12'h00f, 8'h03);
    pf(1'b0, 12'h010, 8'h00);
    pf(1'b1, 12'h300, {4'h8, PFDC_LO_JR});
    pf(1'b0, 12'h301, 8'h80);
    pf(1'b1, 12'h282, PFDC_OP_JP_IRR);
    pf(1'b0, 12'h283, 8'h00);
    pf(1'b1, 12'h123, PFDC_OP_DI);
    pf(1'b1, 12'h124, {PFDC_HI_AND, 4'h2});
    pf(1'b0, 12'h125, 8'h00);
    pf(1'b1, 12'h126, 8'h0f);
    run_done();
    rd(PFDC_OFS_IMR, 8'h7f);
    rd(PFDC_OFS_FLAGS, 8'h80);
    $display("test jumps and logic done");
    // Masked request, then granted request
    rst();
    chk_fetch = 1'b0;
    interrupt_acknowledge_cnt = 0;
    wr(PFDC_OFS_IMR, 8'h00);
    wr(PFDC_OFS_SPH, 8'h01);
    wr(PFDC_OFS_SPL, 8'h00);
    wr(PFDC_OFS_CTRL, 8'h03);
    repeat (60) @(posedge clk_i);
    chk(interrupt_acknowledge_cnt, 0, "masked acknowledge");
    wr(PFDC_OFS_CTRL, 8'h02);
    wr(PFDC_OFS_IMR, 8'h80);
    wr(PFDC_OFS_CTRL, 8'h03);
    repeat (100) @(posedge clk_i);
    chk(interrupt_acknowledge_cnt, 1, "acknowledge count");
    rd(PFDC_OFS_IMR, 8'h00);
    rd(PFDC_OFS_SPH, 8'h00);
    rd(PFDC_OFS_SPL, 8'hfd);
    $display("test interrupt done");
    repeat (4) @(posedge clk_i);
    stop_test();
  end
endmodule
`default_nettype wire
